// ---- shared/spg_pkg.sv ----
// spg_pkg: constants and types for the step pulse generator.
// assumes one 10 MHz clock; fixed-point ports are Q16.16, internal rates are Q32.16.
package spg_pkg;
  // ==========================================================
  // clock and timing
  localparam longint CLK_HZ        = 64'd10_000_000;
  localparam longint CLK_PERIOD_NS = 64'd1_000_000_000 / CLK_HZ;
  localparam longint CLK_Q16       = CLK_HZ << 16;
  localparam int     TICK_BITS     = 13;
  localparam longint TICK_CYC      = 64'd1 << TICK_BITS;
  localparam int     PGAIN_SHIFT   = 10;
  localparam int     FRAC_BITS     = 16;
  localparam int     DIV_W         = 96;
  // ==========================================================
  // output formats and pins
  localparam logic [7:0] FMT_STEP_DIR = 8'h00;
  localparam logic [7:0] FMT_UP_DOWN  = 8'h01;
  localparam logic [7:0] FMT_QUAD     = 8'h02;
  localparam logic [7:0] FMT_TABLE    = 8'h03;
  localparam logic [4:0] TABLE_MAX    = 5'h10;
  localparam int         NUM_PINS     = 6;
  localparam int         TABLE_WORDS  = 4;
  localparam logic [2:0] PINS_MIN     = 3'h2;
  localparam logic [2:0] PINS_MAX     = 3'h6;
  // ==========================================================
  // reset values and encodings of the configuration
  localparam logic        MODE_POSITION = 1'b0;
  localparam logic        MODE_VELOCITY = 1'b1;
  localparam logic [31:0] SCALE_DEF     = 32'h0001_0000;
  localparam logic [31:0] MAXVEL_DEF    = 32'h0000_0000;
  localparam logic [31:0] ACCEL_DEF     = 32'h0001_0000;
  localparam logic [31:0] TIME_NS_DEF   = 32'h0000_0064;
  localparam logic [2:0]  PINW_DEF      = 3'h2;
  localparam logic signed [7:0] LATCH_OFF = -8'sh01;
  localparam logic signed [7:0] LATCH_NOW = 8'sh00;
  localparam logic signed [7:0] LATCH_MAX = 8'sh04;
  localparam int          NUM_TIMERS    = 4;
  // ==========================================================
  // state types
  typedef enum logic {P_IDLE, P_ACTIVE} spg_pulse_t;
  typedef enum logic [1:0] {J_POS, J_VEL, J_RMAX} spg_job_t;
endpackage

// ---- rtl/spg_divider.sv ----
// spg_divider: sequential restoring unsigned divider, one bit per clock.
// assumes start is only pulsed while busy is low; divide by zero gives all ones.
`timescale 1ns/1ps
module spg_divider #(
  parameter int W = 96
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         start,
  input  wire logic [W-1:0] numer,
  input  wire logic [W-1:0] denom,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quot
);
  logic [W-1:0]         rem;
  logic [W-1:0]         den;
  logic [$clog2(W):0]   left;
  wire  logic [W:0]     trial = {rem, quot[W-1]};
  wire  logic           fits  = trial >= {1'b0, den};
  wire  logic [W:0]     diff  = trial - {1'b0, den};

  // ==========================================================
  // shift and subtract
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rem  <= '0;
      den  <= '0;
      quot <= '0;
      left <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem  <= '0;
        den  <= denom;
        quot <= numer;
        left <= ($clog2(W)+1)'(W);
        busy <= 1'b1;
      end else if (busy) begin
        rem  <= fits ? diff[W-1:0] : trial[W-1:0];
        quot <= {quot[W-2:0], fits};
        left <= left - 1'b1;
        if (left == ($clog2(W)+1)'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // spg_divider

// ---- rtl/spg_top.sv ----
// spg_top: step pulse generator turning position or velocity commands into
// step/dir, up/down, quadrature or table phase outputs with count feedback.
// assumes all inputs are synchronous to ref_clk; the host updates commands
// with cmd_write and configuration with config_load.
`timescale 1ns/1ps
module spg_top
  import spg_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          resetn,
  input  wire logic                          enable,
  input  wire logic                          cmd_write,
  input  wire logic signed [31:0]            position_cmd,
  input  wire logic signed [31:0]            velocity_cmd,
  input  wire logic                          config_load,
  input  wire logic                          cfg_mode,
  input  wire logic [31:0]                   cfg_scale,
  input  wire logic [31:0]                   cfg_maxvel,
  input  wire logic [31:0]                   cfg_maxaccel,
  input  wire logic [31:0]                   cfg_steplen_ns,
  input  wire logic [31:0]                   cfg_stepspace_ns,
  input  wire logic [31:0]                   cfg_dirsetup_ns,
  input  wire logic [31:0]                   cfg_dirhold_ns,
  input  wire logic [7:0]                    cfg_format,
  input  wire logic [2:0]                    cfg_pin_width,
  input  wire logic [31:0]                   cfg_table [spg_pkg::TABLE_WORDS],
  input  wire logic signed [7:0]             cfg_latch_sel,
  input  wire logic [15:0]                   timer_offset [spg_pkg::NUM_TIMERS],
  output logic [spg_pkg::NUM_PINS-1:0]       step_pins,
  output logic [spg_pkg::NUM_PINS-1:0]       pin_owned,
  output logic signed [31:0]                 step_count,
  output logic signed [31:0]                 latched_count,
  output logic signed [31:0]                 position_feedback,
  output logic signed [31:0]                 velocity_feedback
);
  import spg_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [31:0] ns_to_cyc(input logic [31:0] ns, input logic at_least_one);
    logic [63:0] c;
    c = (64'(ns) + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
    if (at_least_one && c == 64'd0) c = 64'd1;
    return c[31:0];
  endfunction

  // signed Q16.16 times unsigned Q16.16, result Q32.16 steps
  function automatic logic signed [47:0] mul_q16(input logic signed [31:0] a,
                                                 input logic [31:0] b);
    logic signed [64:0] p;
    p = 65'(a) * $signed({33'h0, b});
    return p[63:16];
  endfunction

  function automatic logic signed [47:0] clamp48(input logic signed [47:0] v,
                                                 input logic [47:0] lim);
    logic signed [47:0] l;
    l = $signed(lim);
    if (v > l) return l;
    if (v < -l) return -l;
    return v;
  endfunction

  function automatic logic [30:0] sat31(input logic [DIV_W-1:0] q);
    return (|q[DIV_W-1:31]) ? 31'h7FFF_FFFF : q[30:0];
  endfunction

  // ==========================================================
  // configuration, captured on config_load
  logic               mode;
  logic [31:0]        scale;
  logic [31:0]        maxvel;
  logic [31:0]        maxaccel;
  logic [31:0]        len_cyc;
  logic [31:0]        space_cyc;
  logic [31:0]        setup_cyc;
  logic [31:0]        hold_cyc;
  logic [7:0]         format;
  logic [4:0]         tbl_len;
  logic [2:0]         pin_width;
  logic [31:0]        table_word [TABLE_WORDS];
  logic signed [7:0]  latch_sel;
  logic signed [31:0] tgt_pos;
  logic signed [31:0] tgt_vel;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode      <= MODE_POSITION;
      scale     <= SCALE_DEF;
      maxvel    <= MAXVEL_DEF;
      maxaccel  <= ACCEL_DEF;
      len_cyc   <= ns_to_cyc(TIME_NS_DEF, 1'b1);
      space_cyc <= ns_to_cyc(TIME_NS_DEF, 1'b0);
      setup_cyc <= ns_to_cyc(TIME_NS_DEF, 1'b0);
      hold_cyc  <= ns_to_cyc(TIME_NS_DEF, 1'b0);
      format    <= FMT_STEP_DIR;
      tbl_len   <= TABLE_MAX;
      pin_width <= PINW_DEF;
      latch_sel <= LATCH_OFF;
      for (int i = 0; i < TABLE_WORDS; i++) table_word[i] <= '0;
    end else if (config_load) begin
      mode      <= cfg_mode;
      scale     <= cfg_scale;
      maxvel    <= cfg_maxvel;
      maxaccel  <= cfg_maxaccel;
      len_cyc   <= ns_to_cyc(cfg_steplen_ns, 1'b1);
      space_cyc <= ns_to_cyc(cfg_stepspace_ns, 1'b0);
      setup_cyc <= ns_to_cyc(cfg_dirsetup_ns, 1'b0);
      hold_cyc  <= ns_to_cyc(cfg_dirhold_ns, 1'b0);
      format    <= cfg_format;
      tbl_len   <= (cfg_format > 8'(TABLE_MAX)) ? TABLE_MAX : cfg_format[4:0];
      pin_width <= cfg_pin_width;
      latch_sel <= cfg_latch_sel;
      for (int i = 0; i < TABLE_WORDS; i++) table_word[i] <= cfg_table[i];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tgt_pos <= '0;
      tgt_vel <= '0;
    end else if (cmd_write) begin
      tgt_pos <= position_cmd;
      tgt_vel <= velocity_cmd;
    end
  end

  // ==========================================================
  // rate planning, all rates in Q16 steps per second
  logic signed [47:0] rate;
  logic [47:0]        rmax;
  logic [TICK_BITS-1:0] tick_cnt;
  spg_pulse_t         pstate;
  logic               dir_out;

  wire logic signed [47:0] tgt_steps = mul_q16(tgt_pos, scale);
  wire logic signed [47:0] vel_steps = mul_q16(tgt_vel, scale);
  wire logic signed [47:0] vmax_st   = mul_q16($signed(maxvel), scale);
  wire logic signed [47:0] acc_st    = mul_q16($signed(maxaccel), scale);
  wire logic signed [47:0] err       = tgt_steps - $signed({step_count, 16'h0});
  wire logic [47:0] vlim = (maxvel != '0 && vmax_st > 48'sd0 && vmax_st < $signed(rmax))
                           ? vmax_st : rmax;
  wire logic signed [47:0] want = clamp48((mode == MODE_VELOCITY) ? vel_steps
                                          : (err <<< PGAIN_SHIFT), vlim);
  wire logic [63:0]        delta64 = (64'(acc_st) * TICK_CYC) / CLK_HZ;
  wire logic signed [47:0] delta   = $signed(delta64[47:0]);
  wire logic               tick    = tick_cnt == '0;
  logic signed [47:0]      next_rate;

  always_comb begin
    next_rate = rate;
    if (!enable) next_rate = '0;
    else if (maxaccel == '0) next_rate = want;
    else if (tick) begin
      if (want > rate + delta) next_rate = rate + delta;
      else if (want < rate - delta) next_rate = rate - delta;
      else next_rate = want;
    end
    next_rate = clamp48(next_rate, vlim);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rate     <= '0;
      tick_cnt <= '0;
    end else begin
      rate     <= next_rate;
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // ==========================================================
  // phase accumulator: one step each time it passes CLK_Q16, one whole step
  logic [47:0] acc;
  logic        pend;
  logic        pend_dir;
  logic [31:0] space_cnt;
  logic [31:0] hold_cnt;
  logic [31:0] setup_cnt;

  wire logic [47:0] rate_mag = rate[47] ? 48'(-rate) : 48'(rate);
  wire logic [47:0] acc_add  = acc + rate_mag;
  wire logic        idle_req = pstate == P_IDLE && pend && enable;
  wire logic start_now  = idle_req && pend_dir == dir_out
                          && setup_cnt == '0 && space_cnt == '0;
  wire logic dir_change = idle_req && pend_dir != dir_out && hold_cnt == '0;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc      <= '0;
      pend     <= 1'b0;
      pend_dir <= 1'b1;
    end else if (!enable) begin
      acc  <= '0;
      pend <= 1'b0;
    end else if (pend) begin
      pend <= !start_now;
    end else if (acc_add >= 48'(CLK_Q16)) begin
      acc      <= acc_add - 48'(CLK_Q16);
      pend     <= 1'b1;
      pend_dir <= !rate[47];
    end else begin
      acc <= acc_add;
    end
  end

  // ==========================================================
  // pulse engine
  logic [31:0] ptmr;
  logic [1:0]  qk;
  logic [3:0]  phase;
  wire  logic  is_quad  = format == FMT_QUAD;
  wire  logic  is_table = format >= FMT_TABLE;
  wire  logic  expire   = pstate == P_ACTIVE && ptmr <= 32'd1;
  wire  logic [1:0] qk_next = dir_out ? qk + 2'd1 : qk - 2'd1;
  wire  logic [3:0] tbl_last = 4'(tbl_len - 5'd1);
  wire  logic [3:0] phase_next = dir_out ? ((phase >= tbl_last) ? 4'h0 : phase + 4'h1)
                                         : ((phase == 4'h0) ? tbl_last : phase - 4'h1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pstate     <= P_IDLE;
      ptmr       <= '0;
      qk         <= '0;
      phase      <= '0;
      dir_out    <= 1'b1;
      space_cnt  <= '0;
      hold_cnt   <= '0;
      setup_cnt  <= '0;
      step_count <= '0;
    end else begin
      if (space_cnt != '0) space_cnt <= space_cnt - 1'b1;
      if (hold_cnt != '0) hold_cnt <= hold_cnt - 1'b1;
      if (setup_cnt != '0) setup_cnt <= setup_cnt - 1'b1;
      case (pstate)
        P_IDLE: begin
          if (dir_change) begin
            dir_out   <= pend_dir;
            setup_cnt <= setup_cyc;
          end else if (start_now) begin
            step_count <= dir_out ? step_count + 32'sd1 : step_count - 32'sd1;
            ptmr       <= len_cyc;
            pstate     <= P_ACTIVE;
            qk         <= is_quad ? (dir_out ? 2'd1 : 2'd3) : 2'd0;
            if (is_table) phase <= phase_next;
          end
        end
        P_ACTIVE: begin
          if (!expire) begin
            ptmr <= ptmr - 1'b1;
          end else if (is_quad && qk_next != 2'd0) begin
            qk   <= qk_next;
            ptmr <= len_cyc;
          end else begin
            qk        <= 2'd0;
            pstate    <= P_IDLE;
            space_cnt <= space_cyc;
            hold_cnt  <= hold_cyc;
          end
        end
        default: pstate <= P_IDLE;
      endcase
    end
  end

  // ==========================================================
  // output formatting
  wire logic       active   = pstate == P_ACTIVE;
  // byte zero of word zero first
  wire logic [7:0] tbl_byte = table_word[phase[3:2]][8*phase[1:0] +: 8];
  wire logic [2:0] nown = !is_table ? PINS_MIN
                        : (pin_width < PINS_MIN) ? PINS_MIN
                        : (pin_width > PINS_MAX) ? PINS_MAX : pin_width;
  wire logic [NUM_PINS-1:0] own_mask = NUM_PINS'((7'h01 << nown) - 7'h01);
  logic [NUM_PINS-1:0] next_pins;

  always_comb begin
    case (format)
      FMT_STEP_DIR: next_pins = {4'h0, dir_out, active};
      FMT_UP_DOWN:  next_pins = {4'h0, active & ~dir_out, active & dir_out};
      FMT_QUAD:     next_pins = {4'h0, qk[1], qk[1] ^ qk[0]};
      default:      next_pins = tbl_byte[NUM_PINS-1:0];
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      step_pins <= '0;
      pin_owned <= '0;
    end else begin
      step_pins <= next_pins & own_mask;
      pin_owned <= own_mask;
    end
  end

  // ==========================================================
  // count latch
  logic [15:0] lat_cnt;
  logic        lat_arm;
  wire  logic  sel_timer = latch_sel > LATCH_NOW && latch_sel <= LATCH_MAX;
  wire  logic [1:0] tsel = 2'(latch_sel - 8'sd1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lat_cnt       <= '0;
      lat_arm       <= 1'b0;
      latched_count <= '0;
    end else if (cmd_write && latch_sel == LATCH_NOW) begin
      latched_count <= step_count;
      lat_arm       <= 1'b0;
    end else if (cmd_write && sel_timer) begin
      lat_cnt <= timer_offset[tsel];
      lat_arm <= 1'b1;
    end else if (lat_arm) begin
      if (lat_cnt == '0) begin
        latched_count <= step_count;
        lat_arm       <= 1'b0;
      end else begin
        lat_cnt <= lat_cnt - 1'b1;
      end
    end
  end

  // ==========================================================
  // feedback: one divider shared round-robin between three jobs
  spg_job_t         job;
  logic             dv_start;
  logic             dv_busy;
  logic             dv_done;
  logic             fb_neg;
  logic [DIV_W-1:0] dv_num;
  logic [DIV_W-1:0] dv_den;
  logic [DIV_W-1:0] dv_quot;

  wire logic signed [79:0] acc_s   = $signed(80'(acc));
  wire logic signed [79:0] pos_raw = 80'(step_count) * $signed(80'(CLK_Q16))
                                     + (dir_out ? acc_s : -acc_s);
  wire logic [79:0]        pos_mag = pos_raw[79] ? 80'(-pos_raw) : 80'(pos_raw);
  wire logic [31:0]        period  = is_quad ? 32'(3 * len_cyc + space_cyc)
                                             : len_cyc + space_cyc;

  always_comb begin
    dv_num = DIV_W'(CLK_Q16);
    dv_den = DIV_W'(period);
    case (job)
      J_POS: begin
        dv_num = {pos_mag, 16'h0};
        dv_den = DIV_W'(64'(CLK_HZ) * 64'(scale));
      end
      J_VEL: begin
        dv_num = DIV_W'({rate_mag, 16'h0});
        dv_den = DIV_W'(scale);
      end
      J_RMAX: begin
        dv_num = DIV_W'(CLK_Q16);
        dv_den = DIV_W'(period);
      end
      default: begin
        dv_num = DIV_W'(CLK_Q16);
        dv_den = DIV_W'(period);
      end
    endcase
  end

  assign dv_start = !dv_busy && !dv_done;

  spg_divider #(
    .W (DIV_W)
  ) u_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .start   (dv_start),
    .numer   (dv_num),
    .denom   (dv_den),
    .busy    (dv_busy),
    .done    (dv_done),
    .quot    (dv_quot)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      job               <= J_RMAX;
      fb_neg            <= 1'b0;
      rmax              <= '0;
      position_feedback <= '0;
      velocity_feedback <= '0;
    end else begin
      if (dv_start) fb_neg <= (job == J_POS) ? pos_raw[79] : rate[47];
      if (dv_done) begin
        case (job)
          J_POS: begin
            position_feedback <= fb_neg ? -$signed({1'b0, sat31(dv_quot)})
                                        : $signed({1'b0, sat31(dv_quot)});
            job <= J_VEL;
          end
          J_VEL: begin
            velocity_feedback <= fb_neg ? -$signed({1'b0, sat31(dv_quot)})
                                        : $signed({1'b0, sat31(dv_quot)});
            job <= J_RMAX;
          end
          J_RMAX: begin
            rmax <= (|dv_quot[DIV_W-1:48]) ? 48'(CLK_Q16) : dv_quot[47:0];
            job  <= J_POS;
          end
          default: job <= J_POS;
        endcase
      end
      if (!enable) velocity_feedback <= '0;
    end
  end
endmodule // spg_top

// ---- testbench/spg_top_assertions.sv ----
// spg_top_assertions: port-level checks of the step pulse generator.
// assumes pulse timings of at least 100 ns; bound to spg_top below.
`timescale 1ns/1ps
module spg_top_assertions
  import spg_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        resetn,
  input wire logic                        enable,
  input wire logic                        config_load,
  input wire logic [7:0]                  cfg_format,
  input wire logic [spg_pkg::NUM_PINS-1:0] step_pins,
  input wire logic [spg_pkg::NUM_PINS-1:0] pin_owned,
  input wire logic signed [31:0]          step_count,
  input wire logic signed [31:0]          velocity_feedback
);
  import spg_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // format shadow, taken on the same strobe as the design
  logic [7:0] fmt;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn) fmt <= FMT_STEP_DIR;
    else if (config_load) fmt <= cfg_format;
  // ==========================================================
  // properties
  sequence s_go; fmt == FMT_STEP_DIR && $changed(step_count); endsequence
  sequence s_end; fmt == FMT_STEP_DIR && $fell(step_pins[0]); endsequence
  property p_vel_off; !enable |=> velocity_feedback == 32'sh0; endproperty
  property p_one; $changed(step_count) |-> (step_count - $past(step_count)) inside {1, -1};
  endproperty
  property p_idle; !enable && !$past(enable) |-> $stable(step_count); endproperty
  property p_unowned; (step_pins & ~pin_owned) == '0; endproperty
  property p_rise; s_go |=> $rose(step_pins[0]); endproperty
  property p_setup; fmt == FMT_STEP_DIR && $rose(step_pins[0]) |-> $stable(step_pins[1]);
  endproperty
  property p_hold; s_end |-> $stable(step_pins[1]) ##1 $stable(step_pins[1]); endproperty
  property p_space; s_end |-> !step_pins[0] ##1 !step_pins[0]; endproperty
  property p_quad; fmt == FMT_QUAD && $past(fmt, 2) == FMT_QUAD |->
    $onehot0(2'(step_pins ^ $past(step_pins))); endproperty
  a_vel_off: assert property (p_vel_off) else $error("velocity not zero");
  a_one: assert property (p_one) else $error("count jump");
  a_idle: assert property (p_idle) else $error("step while disabled");
  a_unowned: assert property (p_unowned) else $error("unowned pin driven");
  a_rise: assert property (p_rise) else $error("no pulse after count");
  a_setup: assert property (p_setup) else $error("dir moved at pulse");
  a_hold: assert property (p_hold) else $error("dir moved after pulse");
  a_space: assert property (p_space) else $error("pulse spacing short");
  a_quad: assert property (p_quad) else $error("quad not gray");
endmodule // spg_top_assertions

bind spg_top spg_top_assertions u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .enable(enable), .config_load(config_load), .cfg_format(cfg_format),
  .step_pins(step_pins), .pin_owned(pin_owned), .step_count(step_count),
  .velocity_feedback(velocity_feedback));

// ---- testbench/spg_drv_model.sv ----
// spg_drv_model: driver input stage counting step/dir pulses.
// assumes step/dir format; other formats are not decoded.
`timescale 1ns/1ps
module spg_drv_model (
  input  wire logic          ref_clk,
  input  wire logic          step,
  input  wire logic          dir,
  output logic signed [31:0] motor_pos
);
  logic step_q = 1'b0;
  initial motor_pos = '0;
  always @(posedge ref_clk) begin
    step_q <= step;
    if (step && !step_q) motor_pos <= motor_pos + (dir ? 32'sh1 : -32'sh1);
  end
endmodule // spg_drv_model

// ---- testbench/spg_top_tb.sv ----
// spg_top_tb: directed sequences on the step pulse generator.
// assumes a 10 MHz ref_clk; commands are Q16.16, scale is 2 steps/unit.
`timescale 1ns/1ps
module spg_top_tb;
  import spg_pkg::*;
  logic ref_clk, resetn, enable, cmd_write, config_load, cfg_mode;
  logic signed [31:0] position_cmd, velocity_cmd, step_count, latched_count;
  logic signed [31:0] position_feedback, velocity_feedback, motor_pos, saved;
  logic [31:0] cfg_scale, cfg_maxvel, cfg_maxaccel, cfg_table [TABLE_WORDS];
  logic [31:0] cfg_steplen_ns, cfg_stepspace_ns, cfg_dirsetup_ns, cfg_dirhold_ns;
  logic [7:0] cfg_format;
  logic [2:0] cfg_pin_width;
  logic signed [7:0] cfg_latch_sel;
  logic [15:0] timer_offset [NUM_TIMERS];
  logic [NUM_PINS-1:0] step_pins, pin_owned;
  int n_fail = 0, total_checks = 0, cycles = 0;
  spg_top u_spg_top (.ref_clk, .resetn, .enable, .cmd_write, .position_cmd,
    .velocity_cmd, .config_load, .cfg_mode, .cfg_scale, .cfg_maxvel, .cfg_maxaccel,
    .cfg_steplen_ns, .cfg_stepspace_ns, .cfg_dirsetup_ns, .cfg_dirhold_ns, .cfg_format,
    .cfg_pin_width, .cfg_table, .cfg_latch_sel, .timer_offset, .step_pins, .pin_owned,
    .step_count, .latched_count, .position_feedback, .velocity_feedback);
  spg_drv_model u_spg_drv_model (.ref_clk, .step(step_pins[0]), .dir(step_pins[1]),
    .motor_pos);
  initial begin ref_clk = 1'b0; forever #50 ref_clk = ~ref_clk; end
  // ==========================================================
  // tasks
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n); repeat (n) @(posedge ref_clk); endtask
  task automatic cfg(logic m, logic [7:0] f, logic [2:0] w, logic signed [7:0] l);
    @(posedge ref_clk);
    {cfg_mode, cfg_format, cfg_pin_width, cfg_latch_sel} <= {m, f, w, l};
    config_load <= 1'b1;
    @(posedge ref_clk);
    config_load <= 1'b0;
  endtask
  task automatic cmd(logic signed [31:0] p, logic signed [31:0] v);
    @(posedge ref_clk);
    {position_cmd, velocity_cmd, cmd_write} <= {p, v, 1'b1};
    @(posedge ref_clk);
    cmd_write <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin n_fail++; print_verdict; end
  end
  // ==========================================================
  // main sequence
  initial begin
    {resetn, enable, cmd_write, config_load, cfg_mode, position_cmd} = '0;
    {velocity_cmd, cfg_maxvel, cfg_maxaccel, cfg_format, saved} = '0;
    {cfg_steplen_ns, cfg_dirsetup_ns, cfg_dirhold_ns} = {3{32'h0000_00C8}};
    {cfg_stepspace_ns, cfg_scale} = {32'h0000_012C, 32'h0002_0000};
    {cfg_pin_width, cfg_latch_sel} = {PINW_DEF, LATCH_OFF};
    foreach (cfg_table[i]) cfg_table[i] = '0;
    foreach (timer_offset[i]) timer_offset[i] = 16'h0014;
    cyc(10);
    resetn <= 1'b1;
    cyc(2);
    check("count", 32'h0, step_count);
    check("owned", 32'h3, 32'(pin_owned));
    // acceleration limit off: commands stay within reach
    cfg(MODE_POSITION, FMT_STEP_DIR, 3'h2, LATCH_OFF);
    enable <= 1'b1;
    cyc(150);
    cmd(32'sh0002_0000, 32'sh7FFF_0000);
    for (int i = 0; i < 40000 && step_count !== 32'sh4; i++) @(posedge ref_clk);
    // enable low clears the sub-step fraction, so feedback is whole steps
    enable <= 1'b0;
    cyc(400);
    check("count", 32'h4, step_count);
    check("posfb", 32'h0002_0000, position_feedback);
    enable <= 1'b1;
    cfg(MODE_VELOCITY, FMT_STEP_DIR, 3'h2, LATCH_OFF);
    cyc(150);
    cmd(32'sh0064_0000, -32'sh2710_0000);
    cyc(4000);
    check("reverse", 32'h1, 32'(step_count < 0));
    check("velfb", 32'hD8F0_0000, velocity_feedback);
    enable <= 1'b0;
    cyc(3);
    saved = step_count;
    check("velfb", 32'h0, velocity_feedback);
    cyc(1000);
    check("stop", saved, step_count);
    check("motor", saved, motor_pos);
    check("latch", 32'h0, latched_count);
    cfg(MODE_VELOCITY, FMT_STEP_DIR, 3'h2, 8'sh02);
    cmd(32'sh0, 32'sh0);
    cyc(10);
    check("latch", 32'h0, latched_count);
    cyc(20);
    check("latch", saved, latched_count);
    cfg(MODE_VELOCITY, FMT_QUAD, 3'h2, LATCH_OFF);
    enable <= 1'b1;
    cyc(150);
    cmd(32'sh0, 32'sh2710_0000);
    cyc(4000);
    check("quad", 32'h1, 32'(step_count > saved));
    cfg_table[0] <= 32'h0804_0201;
    cfg(MODE_VELOCITY, 8'h04, 3'h4, LATCH_OFF);
    repeat (8) begin
      cyc(250);
      check("phase", 32'h1, 32'($onehot(step_pins)));
    end
    check("owned", 32'h0F, 32'(pin_owned));
    // up/down format: a reverse step shows only on the down pin
    cfg(MODE_VELOCITY, FMT_UP_DOWN, 3'h2, LATCH_OFF);
    cmd(32'sh0, -32'sh2710_0000);
    for (int i = 0; i < 2000 && step_pins[1] !== 1'b1; i++) @(posedge ref_clk);
    check("down", 32'h2, 32'(step_pins));
    print_verdict;
  end
endmodule // spg_top_tb
